// File: hdl/reset_sources_and_watchdog.sv
// reset source combining, start-up stretch and watchdog with avalon slave
`include "rsw_map.svh"

module reset_sources_and_watchdog
  import rsw_pkg::*;
#(
  parameter int STARTUP_DELAY_CYCLES = `RSW_STARTUP_CYCLES,
  parameter int BOD_MIN_CYCLES       = `RSW_BOD_MIN_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        reset_pin_n,
  input  wire logic        reset_pin_disable_fuse,
  input  wire logic        power_on_detect,
  input  wire logic        low_supply_detect,
  input  wire logic [2:0]  low_supply_level_fuses,
  input  wire logic        always_on_fuse,
  input  wire logic        comparator_reference_select,
  input  wire logic        converter_enable,
  input  wire logic        wd_osc_clk,
  input  wire logic        wd_restart,
  input  wire logic        irq_vector_ack,
  output logic             timeout_irq,
  output logic             internal_reset,
  output logic             reference_enable
);
  localparam int SW = $clog2(STARTUP_DELAY_CYCLES + 1);
  localparam logic [7:0] CTRL_INIT = `RSW_CTRL_RESET;

  logic          served;
  logic          wr_ctrl;
  logic          wr_flags;
  logic [7:0]    wdat;
  logic [31:0]   rd_mux;
  logic          ctl_clr;
  logic          irq_flag;
  logic          irq_enable;
  logic          rst_enable;
  logic [3:0]    sel;
  logic [3:0]    sel_eff;
  logic [2:0]    unlock_cnt;
  logic          unlock_open;
  logic          unlock_req;
  logic          rst_en_eff;
  logic          irq_en_eff;
  wd_mode_t      wd_mode;
  logic          osc_s;
  logic          osc_prev;
  logic          tick;
  logic [20:0]   wd_count;
  logic [20:0]   wd_limit;
  logic          timeout;
  logic          irq_event;
  logic          wd_reset_pulse;
  logic [3:0]    flags;
  logic          bod_enabled;
  logic          bod_hit;
  logic          pin_active;
  logic          sources_now;
  logic [SW-1:0] stretch_cnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ============================================================
  // avalon slave: one wait cycle on every access
  always_ff @(posedge core_clk) begin
    if (reset) begin
      served <= 1'b0;
    end else begin
      served <= (avs_read || avs_write) && !served;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !served;
  assign wdat     = avs_writedata[7:0];
  assign wr_ctrl  = avs_write && served && avs_byteenable[0]
                    && (avs_address == `RSW_CTRL_OFS) && !ctl_clr;
  assign wr_flags = avs_write && served && avs_byteenable[0]
                    && (avs_address == `RSW_FLAGS_OFS);

  // read mux, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `RSW_CTRL_OFS: begin
        rd_mux[`RSW_IRQ_FLAG_BIT] = irq_flag;
        rd_mux[`RSW_IRQ_EN_BIT]   = irq_en_eff;
        rd_mux[`RSW_SEL_HI_BIT]   = sel[3];
        rd_mux[`RSW_UNLOCK_BIT]   = unlock_open;
        rd_mux[`RSW_RST_EN_BIT]   = rst_en_eff;
        rd_mux[2:0]               = sel[2:0];
      end
      `RSW_FLAGS_OFS: rd_mux[3:0] = flags;
      `RSW_STATE_OFS: begin
        rd_mux[`RSW_ST_REF_BIT]  = reference_enable;
        rd_mux[`RSW_ST_MODE_LSB +: 2] = wd_mode;
        rd_mux[`RSW_ST_RST_BIT]  = internal_reset;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, valid when wait drops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !served) begin
      avs_readdata <= rd_mux;
    end
  end

  AST_BUS_ONE_WAIT: assert property (
    (avs_read || avs_write) && !served |=> !avs_waitrequest)
    else $error("bus access not answered after one wait");

  // ============================================================
  // watchdog mode decode
  assign ctl_clr    = reset || internal_reset;
  assign rst_en_eff = always_on_fuse || rst_enable
                      || flags[`RSW_WDF_BIT];
  assign irq_en_eff = irq_enable && !always_on_fuse;

  always_comb begin
    unique case ({rst_en_eff, irq_en_eff})
      2'b00: wd_mode = WD_STOPPED;
      2'b01: wd_mode = WD_IRQ;
      2'b10: wd_mode = WD_RESET;
      2'b11: wd_mode = WD_IRQ_RESET;
    endcase
  end

  AST_ALWAYS_ON_MODE: assert property (
    always_on_fuse |-> wd_mode == WD_RESET)
    else $error("always-on fuse did not force reset mode");

  AST_FLAG_HOLDS_RESET: assert property (
    flags[`RSW_WDF_BIT] && !wr_flags && !power_on_detect |=> rst_en_eff)
    else $error("watchdog flag did not hold reset enable");

  // ============================================================
  // timed unlock window
  assign unlock_req  = wr_ctrl && wdat[`RSW_UNLOCK_BIT]
                       && wdat[`RSW_RST_EN_BIT];
  assign unlock_open = (unlock_cnt != 3'h0);

  always_ff @(posedge core_clk) begin
    if (ctl_clr) begin
      unlock_cnt <= 3'h0;
    end else if (unlock_req) begin
      unlock_cnt <= `RSW_UNLOCK_CYC;
    end else if (unlock_open) begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  AST_UNLOCK_CLOSES: assert property (
    unlock_req ##1 (!unlock_req)[*4] |-> unlock_open ##1 !unlock_open)
    else $error("unlock window not closed after four cycles");

  // reset enable and select, protected changes only in window
  always_ff @(posedge core_clk) begin
    if (ctl_clr) begin
      rst_enable <= CTRL_INIT[`RSW_RST_EN_BIT];
      sel        <= 4'h0;
    end else if (wr_ctrl && unlock_open
                 && !wdat[`RSW_UNLOCK_BIT]) begin
      rst_enable <= wdat[`RSW_RST_EN_BIT];
      sel        <= {wdat[`RSW_SEL_HI_BIT], wdat[2:0]};
    end else if (wr_ctrl && wdat[`RSW_RST_EN_BIT]) begin
      rst_enable <= 1'b1;
    end
  end

  AST_SEL_PROTECTED: assert property (
    !unlock_open && !ctl_clr |=> $stable(sel))
    else $error("select changed outside unlock window");

  // interrupt enable, vector in combined mode falls back to reset mode
  always_ff @(posedge core_clk) begin
    if (ctl_clr) begin
      irq_enable <= CTRL_INIT[`RSW_IRQ_EN_BIT];
    end else if (irq_vector_ack && rst_en_eff) begin
      irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
      irq_enable <= wdat[`RSW_IRQ_EN_BIT];
    end
  end

  // ============================================================
  // oscillator edge detect after synchroniser
  level_sync u_osc_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (wd_osc_clk),
    .dout     (osc_s)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= osc_s;
    end
  end

  assign tick = osc_s && !osc_prev;

  // time-out count, reserved codes behave as the longest
  assign sel_eff  = (sel > `RSW_SEL_MAX) ? `RSW_SEL_MAX : sel;
  assign wd_limit = (21'h00_0001 << (`RSW_WD_BASE_LOG2 + 5'(sel_eff)))
                    - 21'h00_0001;
  assign timeout  = tick && (wd_count == wd_limit)
                    && (wd_mode != WD_STOPPED);

  always_ff @(posedge core_clk) begin
    if (ctl_clr || wd_restart || wd_mode == WD_STOPPED) begin
      wd_count <= 21'h00_0000;
    end else if (tick) begin
      if (wd_count == wd_limit) begin
        wd_count <= 21'h00_0000;
      end else begin
        wd_count <= wd_count + 21'h00_0001;
      end
    end
  end

  AST_RESTART_ZERO: assert property (
    wd_restart |=> wd_count == 21'h00_0000)
    else $error("restart did not clear the count");

  AST_COUNT_ON_TICK: assert property (
    !tick && !wd_restart && !ctl_clr && wd_mode != WD_STOPPED
    |=> $stable(wd_count))
    else $error("count moved without oscillator edge");

  // ============================================================
  // time-out actions
  assign irq_event = timeout && (wd_mode == WD_IRQ
                     || (wd_mode == WD_IRQ_RESET && !irq_flag));

  always_ff @(posedge core_clk) begin
    if (ctl_clr) begin
      wd_reset_pulse <= 1'b0;
    end else begin
      wd_reset_pulse <= timeout && (wd_mode == WD_RESET
                        || (wd_mode == WD_IRQ_RESET && irq_flag));
    end
  end

  AST_WD_RESET_CAUSE: assert property (
    $rose(wd_reset_pulse) |-> $past(timeout) && $past(rst_en_eff))
    else $error("watchdog reset without reset-mode expiry");

  AST_WD_PULSE_ONE: assert property (
    wd_reset_pulse |=> !wd_reset_pulse)
    else $error("watchdog reset pulse longer than one cycle");

  // interrupt flag, set wins over both clears
  always_ff @(posedge core_clk) begin
    if (ctl_clr) begin
      irq_flag <= 1'b0;
    end else if (irq_event) begin
      irq_flag <= 1'b1;
    end else if (irq_vector_ack
                 || (wr_ctrl && wdat[`RSW_IRQ_FLAG_BIT])) begin
      irq_flag <= 1'b0;
    end
  end

  assign timeout_irq = irq_flag && irq_en_eff;

  AST_IRQ_SETS: assert property (
    irq_event |=> irq_flag ##0 (timeout_irq || !irq_en_eff))
    else $error("time-out did not raise interrupt flag");

  // ============================================================
  // reset sources
  assign bod_enabled = (low_supply_level_fuses != `RSW_FUSES_OFF);
  assign pin_active  = !reset_pin_n && !reset_pin_disable_fuse;

  persist_filter #(
    .HOLD_CYCLES (BOD_MIN_CYCLES)
  ) u_bod_filter (
    .core_clk (core_clk),
    .reset    (reset),
    .din      (low_supply_detect && bod_enabled),
    .dout     (bod_hit)
  );

  assign sources_now = power_on_detect || pin_active
                       || bod_hit || wd_reset_pulse;

  // start-up stretch reloads while any source is active
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stretch_cnt <= SW'(STARTUP_DELAY_CYCLES);
    end else if (sources_now) begin
      stretch_cnt <= SW'(STARTUP_DELAY_CYCLES);
    end else if (stretch_cnt != '0) begin
      stretch_cnt <= stretch_cnt - 1'b1;
    end
  end

  // immediate assertion with no clock, stretched release
  assign internal_reset = sources_now || (stretch_cnt != '0);

  AST_IMMEDIATE_RESET: assert property (
    power_on_detect || pin_active || bod_hit |-> internal_reset)
    else $error("active source did not reset");

  AST_STRETCH_HOLDS: assert property (
    $fell(sources_now) |-> internal_reset ##1 internal_reset)
    else $error("reset released before start-up delay");

  // reset cause flags, write zero clears, hardware set wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags <= `RSW_FLAGS_RESET;
    end else if (power_on_detect) begin
      flags <= 4'h1 << `RSW_PORF_BIT;
    end else begin
      flags <= (wr_flags ? (flags & wdat[3:0]) : flags)
               | {wd_reset_pulse, bod_hit, pin_active, 1'b0};
    end
  end

  // ============================================================
  // bandgap reference request
  assign reference_enable = bod_enabled || comparator_reference_select
                            || converter_enable;
endmodule // reset_sources_and_watchdog

// File: hdl/rsw_map.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

// ============================================================
// register byte offsets
`define RSW_CTRL_OFS     4'h0
`define RSW_FLAGS_OFS    4'h4
`define RSW_STATE_OFS    4'h8

// ============================================================
// control register fields
`define RSW_IRQ_FLAG_BIT 7
`define RSW_IRQ_EN_BIT   6
`define RSW_SEL_HI_BIT   5
`define RSW_UNLOCK_BIT   4
`define RSW_RST_EN_BIT   3

// reset cause flag fields
`define RSW_WDF_BIT      3
`define RSW_BODF_BIT     2
`define RSW_EXTF_BIT     1
`define RSW_PORF_BIT     0

// state register fields
`define RSW_ST_REF_BIT   0
`define RSW_ST_MODE_LSB  1
`define RSW_ST_RST_BIT   3

// ============================================================
// reset values and codes
`define RSW_CTRL_RESET   8'h00
`define RSW_FLAGS_RESET  4'h0
`define RSW_UNLOCK_CYC   3'h4
`define RSW_SEL_MAX      4'h9
`define RSW_WD_BASE_LOG2 5'h0b
`define RSW_FUSES_OFF    3'h7

// ============================================================
// timing
`define RSW_CLK_PERIOD_NS    8
`define RSW_BOD_MIN_NS       2000
`define RSW_STARTUP_NS       64000
`define RSW_BOD_MIN_CYCLES \
  ((`RSW_BOD_MIN_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS)
`define RSW_STARTUP_CYCLES \
  ((`RSW_STARTUP_NS + `RSW_CLK_PERIOD_NS - 1) / `RSW_CLK_PERIOD_NS)

`endif

// File: hdl/rsw_pkg.sv
// types shared by the reset and watchdog block
package rsw_pkg;
  // watchdog operating mode
  typedef enum logic [1:0] {
    WD_STOPPED,
    WD_IRQ,
    WD_RESET,
    WD_IRQ_RESET
  } wd_mode_t;
endpackage

// File: hdl/level_sync.sv
// two flip-flop synchroniser for one level
module level_sync (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta;

  // first stage is read only by the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // level_sync

// File: hdl/persist_filter.sv
// passes a level only once it has persisted for a minimum time
module persist_filter #(
  parameter int HOLD_CYCLES = 250
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  logic [CW-1:0] cnt;

  // count while the input stays high, restart on any drop
  always_ff @(posedge core_clk) begin
    if (reset || !din) begin
      cnt <= '0;
    end else if (cnt != CW'(HOLD_CYCLES)) begin
      cnt <= cnt + 1'b1;
    end
  end

  // release follows the input at once
  assign dout = din && (cnt == CW'(HOLD_CYCLES));

  AST_FILTER_PERSIST: assert property (@(posedge core_clk) disable iff (reset)
    $rose(dout) |-> $past(din) && $past(cnt) == CW'(HOLD_CYCLES - 1))
    else $error("filter passed a short pulse");
endmodule // persist_filter

// File: verif/rsw_cpu_model.sv
// processor core and reset pin model on the block's far side
module rsw_cpu_model (
  input  wire logic core_clk,
  output logic      wd_restart,
  output logic      irq_vector_ack,
  output logic      reset_pin_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========
  // idle: no instruction, pin released high
  initial begin
    wd_restart     = 1'b0;
    irq_vector_ack = 1'b0;
    reset_pin_n    = 1'b1;
  end

  // restart instruction, one cycle pulse
  task automatic restart();
    @(posedge core_clk) wd_restart <= 1'b1;
    @(posedge core_clk) wd_restart <= 1'b0;
  endtask

  // interrupt vector executed, one cycle pulse
  task automatic vector();
    @(posedge core_clk) irq_vector_ack <= 1'b1;
    @(posedge core_clk) irq_vector_ack <= 1'b0;
  endtask

  // pin held low for n cycles, then released
  task automatic pin_low(input int n);
    @(posedge core_clk) reset_pin_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    reset_pin_n <= 1'b1;
  endtask
endmodule // rsw_cpu_model

// File: verif/reset_sources_and_watchdog_tb.sv
// self-checking bench for reset combining and the watchdog
`include "rsw_map.svh"
module reset_sources_and_watchdog_tb
  import rsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STARTUP = 8;
  localparam int BOD_MIN = 4;
  localparam logic [3:0] CTL = `RSW_CTRL_OFS;
  localparam logic [3:0] FLG = `RSW_FLAGS_OFS;

  logic        core_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic        reset_pin_n, reset_pin_disable_fuse, power_on_detect;
  logic        low_supply_detect, always_on_fuse;
  logic [2:0]  low_supply_level_fuses;
  logic        comparator_reference_select, converter_enable, wd_osc_clk;
  logic        wd_restart, irq_vector_ack, timeout_irq;
  logic        internal_reset, reference_enable, saw_rst;
  int          num_errors;
  int          n_tests;

  // ==========
  // design and far-side model
  reset_sources_and_watchdog #(
    .STARTUP_DELAY_CYCLES (STARTUP),
    .BOD_MIN_CYCLES       (BOD_MIN)
  ) u_dut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_pin_n(reset_pin_n),
    .reset_pin_disable_fuse(reset_pin_disable_fuse),
    .power_on_detect(power_on_detect),
    .low_supply_detect(low_supply_detect),
    .low_supply_level_fuses(low_supply_level_fuses),
    .always_on_fuse(always_on_fuse),
    .comparator_reference_select(comparator_reference_select),
    .converter_enable(converter_enable), .wd_osc_clk(wd_osc_clk),
    .wd_restart(wd_restart), .irq_vector_ack(irq_vector_ack),
    .timeout_irq(timeout_irq), .internal_reset(internal_reset),
    .reference_enable(reference_enable)
  );
  rsw_cpu_model u_cpu (
    .core_clk(core_clk), .wd_restart(wd_restart),
    .irq_vector_ack(irq_vector_ack), .reset_pin_n(reset_pin_n)
  );

  // ==========
  // clock and sticky reset monitor
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (internal_reset === 1'b1) saw_rst <= 1'b1;

  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= {24'h0, d};
    // look at waitrequest where it is settled, act on the next rising edge
    @(negedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    if (n >= 20) num_errors++;
    @(posedge core_clk);
    rd_val = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_val, {24'h0, e});
  endtask

  // counts cycles reset stays high after the last source went away
  task automatic stretch();
    int n;
    n = 0;
    @(negedge core_clk);
    while (internal_reset === 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk);
    end
    chk(32'(n), 32'(STARTUP));
  endtask

  // oscillator edges, then time for the synchroniser
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge core_clk) wd_osc_clk <= 1'b1;
      @(posedge core_clk) wd_osc_clk <= 1'b0;
    end
    repeat (8) @(negedge core_clk);
  endtask

  task automatic dip(input int n);
    @(posedge core_clk) low_supply_detect <= 1'b1;
    repeat (n) @(posedge core_clk);
    low_supply_detect <= 1'b0;
  endtask

  task automatic clr();
    @(negedge core_clk) saw_rst = 1'b0;
  endtask

  // ==========
  // hang guard
  initial begin
    #400000;
    num_errors++;
    test_done();
  end

  // ==========
  // main sequence
  initial begin
    {reset, avs_read, avs_write, saw_rst} = 4'h8;
    {avs_address, avs_writedata, avs_byteenable} = {4'h0, 32'h0, 4'hf};
    {reset_pin_disable_fuse, power_on_detect, low_supply_detect} = 3'h0;
    {always_on_fuse, comparator_reference_select} = 2'h0;
    {converter_enable, wd_osc_clk} = 2'h0;
    low_supply_level_fuses = `RSW_FUSES_OFF;
    num_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    stretch();
    rd(CTL, 8'h00);
    rd(4'hc, 8'h00);
    // reset sources
    clr();
    u_cpu.pin_low(1);
    stretch();
    chk(saw_rst, 1'b1);
    rd(FLG, 8'h02);
    reset_pin_disable_fuse <= 1'b1;
    clr();
    u_cpu.pin_low(5);
    repeat (2) @(negedge core_clk);
    chk(saw_rst, 1'b0);
    reset_pin_disable_fuse <= 1'b0;
    @(posedge core_clk) power_on_detect <= 1'b1;
    @(negedge core_clk) chk(internal_reset, 1'b1);
    @(posedge core_clk) power_on_detect <= 1'b0;
    stretch();
    rd(FLG, 8'h01);
    low_supply_level_fuses <= 3'h0;
    clr();
    dip(BOD_MIN - 1);
    repeat (4) @(negedge core_clk);
    chk(saw_rst, 1'b0);
    dip(12);
    stretch();
    chk(saw_rst, 1'b1);
    rd(FLG, 8'h05);
    low_supply_level_fuses <= `RSW_FUSES_OFF;
    clr();
    dip(12);
    repeat (4) @(negedge core_clk);
    chk(saw_rst, 1'b0);
    wr(FLG, 8'h00);
    // reference requests, all eight combinations
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      low_supply_level_fuses <= i[0] ? 3'h0 : `RSW_FUSES_OFF;
      comparator_reference_select <= i[1];
      converter_enable <= i[2];
      @(negedge core_clk) chk(reference_enable, 1'(i != 0));
    end
    {comparator_reference_select, converter_enable} <= 2'h0;
    low_supply_level_fuses <= `RSW_FUSES_OFF;
    // timed change sequence
    wr(CTL, 8'h18);
    wr(CTL, 8'h05);
    rd(CTL, 8'h05);
    wr(CTL, 8'h08);
    wr(CTL, 8'h18);
    repeat (6) @(posedge core_clk);
    wr(CTL, 8'h00);
    rd(CTL, 8'h0d);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    wr(4'hc, 8'hff);
    rd(CTL, 8'h00);
    // interrupt mode and restart
    clr();
    wr(CTL, 8'h40);
    rd(`RSW_STATE_OFS, {5'h0, WD_IRQ, 1'b0});
    osc(2047);
    chk(timeout_irq, 1'b0);
    osc(1);
    chk(timeout_irq, 1'b1);
    u_cpu.vector();
    @(negedge core_clk) chk(timeout_irq, 1'b0);
    wr(CTL, 8'h00);
    wr(CTL, 8'h40);
    osc(1000);
    u_cpu.restart();
    osc(2047);
    chk(timeout_irq, 1'b0);
    osc(1);
    chk(timeout_irq, 1'b1);
    chk(saw_rst, 1'b0);
    wr(CTL, 8'hc0);
    rd(CTL, 8'h40);
    // system reset mode and its lock
    wr(CTL, 8'h00);
    wr(CTL, 8'h08);
    clr();
    osc(2047);
    chk(saw_rst, 1'b0);
    osc(1);
    repeat (STARTUP + 4) @(negedge core_clk);
    chk(saw_rst, 1'b1);
    chk(internal_reset, 1'b0);
    rd(FLG, 8'h08);
    rd(CTL, 8'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 8'h08);
    wr(FLG, 8'h00);
    wr(CTL, 8'h18);
    wr(CTL, 8'h00);
    rd(CTL, 8'h00);
    // combined mode: interrupt first, reset next
    wr(CTL, 8'h48);
    clr();
    osc(2048);
    chk(timeout_irq, 1'b1);
    chk(saw_rst, 1'b0);
    osc(2048);
    repeat (16) @(negedge core_clk);
    chk(saw_rst, 1'b1);
    // always-on fuse overrides the enables
    wr(FLG, 8'h00);
    always_on_fuse <= 1'b1;
    wr(CTL, 8'h40);
    rd(CTL, 8'h08);
    test_done();
  end
endmodule // reset_sources_and_watchdog_tb
